/* hdl/dmr_pkg.sv */
// constants, field layout and reset values of the dac mode register bank
// Functional notes
// [RULE_01] control word carries seven-bit index in bits 14..8; registers at 01h..04h
// [RULE_02] index 01h: right mute bit 7, left mute bit 6, left level 5..0
// [RULE_03] index 02h: right level in bits 5..0, bits 7..6 reserved
// [RULE_04] index 03h: oversampling, reserved, invert, mix, de-emphasis, format 2..0
// [RULE_05] index 04h: zero-cross enable bit 4, power-down bit 0, rest reserved
// [RULE_06] host writes zero to every reserved bit in normal operation
// [RULE_07] reset: mutes off, 0 dB, 128x, no invert, all off, format 000
// [RULE_08] each channel has its own mute bit acting on its own path
// [RULE_09] soft mute lives inside each channel's digital attenuator
// [RULE_10] mute clear: attenuator runs at the programmed level
// [RULE_11] mute set: attenuation ramps toward full mute in 1 dB steps
// [RULE_12] mute cleared: ramp back step by step to programmed level
// [RULE_13] mode registers are reachable only through the serial control port
// [RULE_14] write word is 16 bits: bit 15 zero, index, then data byte
// [RULE_15] level code 63 is 0 dB, each lower code 1 dB more, 0 mutes
// [RULE_16] one ramp step of 1 dB per eight sample periods
// [RULE_17] bits sampled on control clock rising edge while select held low
// [RULE_18] a write to an index outside 01h..04h changes nothing
package dmr_pkg;
    localparam int          WORD_BITS     = 16;
    localparam int          INDEX_MSB     = 14;
    localparam int          INDEX_LSB     = 8;
    localparam int          FRAME_BIT     = 15;
    localparam logic [6:0]  INDEX_MUTE_L  = 7'h01;
    localparam logic [6:0]  INDEX_RIGHT   = 7'h02;
    localparam logic [6:0]  INDEX_FORMAT  = 7'h03;
    localparam logic [6:0]  INDEX_ZC_PWR  = 7'h04;
    localparam int          MUTE_R_BIT    = 7;
    localparam int          MUTE_L_BIT    = 6;
    localparam int          OVER_BIT      = 7;
    localparam int          INVERT_BIT    = 5;
    localparam int          MIX_BIT       = 4;
    localparam int          DEEMPH_BIT    = 3;
    localparam int          ZC_EN_BIT     = 4;
    localparam int          POWER_BIT     = 0;
    localparam logic [5:0]  LEVEL_0DB     = 6'h3f;
    localparam logic [5:0]  LEVEL_MUTE    = 6'h00;
    localparam logic [2:0]  FORMAT_RESET  = 3'h0;
    localparam int          SAMPLES_STEP  = 8;
endpackage

/* hdl/dmr_atten_ramp.sv */
// one channel's digital attenuator with soft mute ramp
module dmr_atten_ramp
    import dmr_pkg::*;
#(
    parameter int STEP_SAMPLES = SAMPLES_STEP
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       sample_tick,
    input  wire logic       soft_mute,
    input  wire logic [5:0] atten_level,
    output logic      [5:0] atten_current
);
    localparam int CNT_W = $clog2(STEP_SAMPLES);

    logic [CNT_W-1:0] sample_count;
    logic [5:0]       target;
    logic             step_tick;

    // [RULE_09] mute folded into target
    // [RULE_10] programmed level when unmuted
    assign target = soft_mute ? LEVEL_MUTE : atten_level;

    // [RULE_16] eight samples per step
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_count <= '0;
        end else if (step_tick) begin
            // explicit wrap keeps the period right for counts that are not a power of two
            sample_count <= '0;
        end else if (sample_tick) begin
            sample_count <= sample_count + 1'b1;
        end
    end
    assign step_tick = sample_tick && (sample_count == CNT_W'(STEP_SAMPLES - 1));

    // [RULE_11] single 1 dB steps down
    // [RULE_12] single steps back up
    always_ff @(posedge clk) begin
        if (!resetn) begin
            atten_current <= LEVEL_0DB;
        end else if (step_tick) begin
            if (atten_current > target) begin
                atten_current <= atten_current - 6'h01;
            end else if (atten_current < target) begin
                atten_current <= atten_current + 6'h01;
            end
        end
    end
endmodule

/* hdl/dmr_mode_regs.sv */
// mode register bank behind the three-wire serial control port
module dmr_mode_regs
    import dmr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       control_select_n,
    input  wire logic       control_clock,
    input  wire logic       control_serial_in,
    input  wire logic       sample_tick,
    output logic            left_soft_mute,
    output logic            right_soft_mute,
    output logic      [5:0] left_atten_level,
    output logic      [5:0] right_atten_level,
    output logic      [5:0] left_atten_current,
    output logic      [5:0] right_atten_current,
    output logic            oversample_select,
    output logic            right_polarity_invert,
    output logic            analog_mix_enable,
    output logic            deemphasis_enable,
    output logic      [2:0] audio_format_select,
    output logic            zero_cross_atten_enable,
    output logic            power_down
);
    logic [2:0]  sel_sync;
    logic [2:0]  clk_sync;
    logic [2:0]  din_sync;
    logic        sel_state;
    logic        clk_state;
    logic [15:0] shift;
    logic [4:0]  bit_count;
    logic        word_done;
    logic [15:0] word;
    logic        clk_rise;

    // [RULE_13] pins are the only path in; three-stage sampling
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sel_sync  <= 3'h7;
            clk_sync  <= 3'h0;
            din_sync  <= 3'h0;
            sel_state <= 1'b1;
            clk_state <= 1'b0;
        end else begin
            sel_sync <= {sel_sync[1:0], control_select_n};
            clk_sync <= {clk_sync[1:0], control_clock};
            din_sync <= {din_sync[1:0], control_serial_in};
            if (sel_sync[1] == sel_sync[2]) begin
                sel_state <= sel_sync[2];
            end
            if (clk_sync[1] == clk_sync[2]) begin
                clk_state <= clk_sync[2];
            end
        end
    end

    assign clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_state;

    // [RULE_17] shift on rising control clock while select is low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift     <= '0;
            bit_count <= '0;
            word_done <= 1'b0;
            word      <= '0;
        end else begin
            word_done <= 1'b0;
            if (sel_state) begin
                bit_count <= '0;
            end else if (clk_rise && (bit_count < 5'(WORD_BITS))) begin
                shift     <= {shift[14:0], din_sync[2]};
                bit_count <= bit_count + 5'h01;
                // [RULE_14] sixteenth bit completes the word
                if (bit_count == 5'(WORD_BITS - 1)) begin
                    word      <= {shift[14:0], din_sync[2]};
                    word_done <= 1'b1;
                end
            end
        end
    end

    logic [6:0] register_index;
    logic [7:0] data;
    logic       word_ok;
    assign register_index = word[INDEX_MSB:INDEX_LSB];
    assign data           = word[7:0];
    // [RULE_14] bit 15 must be zero
    assign word_ok = word_done && !word[FRAME_BIT];

    // [RULE_01] decode index; [RULE_18] others ignored
    // [RULE_06] reserved bits are dropped, host keeps them zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // [RULE_07] reset defaults
            left_soft_mute          <= 1'b0;
            right_soft_mute         <= 1'b0;
            left_atten_level        <= LEVEL_0DB;
            right_atten_level       <= LEVEL_0DB;
            oversample_select       <= 1'b0;
            right_polarity_invert   <= 1'b0;
            analog_mix_enable       <= 1'b0;
            deemphasis_enable       <= 1'b0;
            audio_format_select     <= FORMAT_RESET;
            zero_cross_atten_enable <= 1'b0;
            power_down              <= 1'b0;
        end else if (word_ok) begin
            if (register_index == INDEX_MUTE_L) begin
                // [RULE_02] mutes and left level
                right_soft_mute  <= data[MUTE_R_BIT];
                left_soft_mute   <= data[MUTE_L_BIT];
                left_atten_level <= data[5:0];
            end else if (register_index == INDEX_RIGHT) begin
                // [RULE_03] right level
                right_atten_level <= data[5:0];
            end else if (register_index == INDEX_FORMAT) begin
                // [RULE_04] path and format fields
                oversample_select     <= data[OVER_BIT];
                right_polarity_invert <= data[INVERT_BIT];
                analog_mix_enable     <= data[MIX_BIT];
                deemphasis_enable     <= data[DEEMPH_BIT];
                audio_format_select   <= data[2:0];
            end else if (register_index == INDEX_ZC_PWR) begin
                // [RULE_05] zero cross and power down
                zero_cross_atten_enable <= data[ZC_EN_BIT];
                power_down              <= data[POWER_BIT];
            end
        end
    end

    // [RULE_08] independent ramp per channel; [RULE_15] code 63 is 0 dB
    dmr_atten_ramp u_left (
        .clk           (clk),
        .resetn        (resetn),
        .sample_tick   (sample_tick),
        .soft_mute     (left_soft_mute),
        .atten_level   (left_atten_level),
        .atten_current (left_atten_current)
    );

    dmr_atten_ramp u_right (
        .clk           (clk),
        .resetn        (resetn),
        .sample_tick   (sample_tick),
        .soft_mute     (right_soft_mute),
        .atten_level   (right_atten_level),
        .atten_current (right_atten_current)
    );
endmodule

/* tb/dmr_host_model.sv */
// host controller model driving the three-wire control port
module dmr_host_model (
    output logic control_select_n,
    output logic control_clock,
    output logic control_serial_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // control clock stands still low between frames
    initial begin
        control_select_n = 1'b1;
        control_clock = 1'b0;
        control_serial_in = 1'b1;
    end
    // data moves while clock low
    // fewer than 16 bits cuts the frame short, as an aborting host would
    task automatic send(input logic [15:0] w, input int nbits);
        control_select_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            control_serial_in = w[i];
            #100 control_clock = 1'b1;
            #100 control_clock = 1'b0;
        end
        #50 control_select_n = 1'b1;
        // released line shows the inverse so a stale bit cannot pass
        control_serial_in = ~w[16 - nbits];
        #400;
    endtask
endmodule

/* tb/dmr_mode_regs_checker.sv */
// port checks for the mode register bank
module dmr_mode_regs_checker
    import dmr_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       sample_tick,
    input wire logic       control_select_n,
    input wire logic       left_soft_mute,
    input wire logic       right_soft_mute,
    input wire logic       power_down,
    input wire logic [5:0] left_atten_level,
    input wire logic [5:0] right_atten_level,
    input wire logic [5:0] left_atten_current,
    input wire logic [5:0] right_atten_current
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire [5:0]  lc = left_atten_current;
    wire [5:0]  rc = right_atten_current;
    logic [3:0] left_gap;

    // sample ticks since the left level last moved, saturating
    always_ff @(posedge clk) begin
        if (!resetn) begin
            left_gap <= 4'(SAMPLES_STEP);
        end else if ($changed(lc)) begin
            left_gap <= {3'h0, sample_tick};
        end else if (sample_tick && left_gap != 4'hf) begin
            left_gap <= left_gap + 4'h1;
        end
    end

    chk_reset_default:
        assert property (disable iff (1'b0) !resetn |=> lc == LEVEL_0DB && rc == LEVEL_0DB
            && !left_soft_mute && !right_soft_mute && !power_down) else $error("bad reset value");
    chk_left_one_step:
        assert property ($past(resetn) && $changed(lc) |-> lc == $past(lc) + 6'h01
            || lc + 6'h01 == $past(lc)) else $error("left step not one");
    chk_right_one_step:
        assert property ($past(resetn) && $changed(rc) |-> rc == $past(rc) + 6'h01
            || rc + 6'h01 == $past(rc)) else $error("right step not one");
    chk_step_on_tick:
        assert property ($past(resetn) && $changed(lc) |-> $past(sample_tick)
            || $past(sample_tick, 2)) else $error("step without sample");
    chk_mute_no_rise:
        assert property (left_soft_mute && $past(left_soft_mute) |-> lc <= $past(lc))
            else $error("muted level rose");
    chk_rise_to_level:
        assert property ($past(resetn) && lc > $past(lc) |-> lc <= $past(left_atten_level))
            else $error("rose past level");
    chk_hold_at_level:
        assert property (!right_soft_mute && rc == right_atten_level && $stable(right_atten_level)
            && $stable(right_soft_mute) |=> $stable(rc)) else $error("moved at level");
    chk_quiet_link:
        assert property (control_select_n [*8] |=> $stable(left_atten_level) && $stable(power_down))
            else $error("field changed with no frame");
    chk_left_step_gap:
        assert property ($past(resetn) && $changed(lc) |-> left_gap >= 4'(SAMPLES_STEP))
            else $error("left steps closer than eight samples");
endmodule
bind dmr_mode_regs dmr_mode_regs_checker i_dmr_mode_regs_checker (
    .clk(clk), .resetn(resetn), .sample_tick(sample_tick), .control_select_n(control_select_n),
    .left_soft_mute(left_soft_mute), .right_soft_mute(right_soft_mute), .power_down(power_down),
    .left_atten_level(left_atten_level), .right_atten_level(right_atten_level),
    .left_atten_current(left_atten_current), .right_atten_current(right_atten_current)
);

/* tb/test_dmr_mode_regs.sv */
// self-checking bench for the mode register bank
module test_dmr_mode_regs
    import dmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, resetn = 1'b0, sample_tick = 1'b0;
    logic control_select_n, control_clock, control_serial_in, left_soft_mute, right_soft_mute;
    logic oversample_select, right_polarity_invert, analog_mix_enable, deemphasis_enable;
    logic zero_cross_atten_enable, power_down;
    logic [5:0] left_atten_level, right_atten_level, left_atten_current, right_atten_current;
    logic [2:0] audio_format_select;
    logic [7:0] m [1:4];
    logic [7:0] msk [0:7] = '{8'hff, 8'hff, 8'h3f, 8'hbf, 8'h11, 8'hff, 8'hff, 8'hff};
    logic [6:0] reg_index;
    logic [15:0] w;
    int mismatches = 0, checked = 0, tick_cnt = 0;
    wire [22:0] got = {left_soft_mute, right_soft_mute, left_atten_level, right_atten_level,
        oversample_select, right_polarity_invert, analog_mix_enable, deemphasis_enable,
        audio_format_select, zero_cross_atten_enable, power_down};
    dmr_host_model i_dmr_host_model (.*);
    dmr_mode_regs i_dmr_mode_regs (.*);
    always #12.5 clk = ~clk;
    always @(negedge clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        sample_tick <= (tick_cnt == 3);
    end
    function automatic logic [22:0] expf();
        return {m[1][6], m[1][7], m[1][5:0], m[2][5:0], m[3][7], m[3][5:0], m[4][4], m[4][0]};
    endfunction
    task automatic cmp(input logic [22:0] g, input logic [22:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_level(input logic [5:0] g, input logic [5:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t level got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [15:0] v);
        i_dmr_host_model.send(v, 16);
        if (!v[15] && v[14:8] inside {[7'h01:7'h04]}) m[v[10:8]] = v[7:0];
        repeat (20) @(negedge clk);
    endtask
    task automatic settle(input logic [5:0] l, input logic [5:0] r);
        for (int i = 0; i < 4000 && {left_atten_current, right_atten_current} !== {l, r}; i++)
            @(negedge clk);
        cmp_level(left_atten_current, l);
        cmp_level(right_atten_current, r);
    endtask
    task automatic rst();
        resetn = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        m = '{8'h3f, 8'h3f, 8'h00, 8'h00};
        repeat (2) @(negedge clk);
    endtask
    task automatic results();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #2ms;
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(25420));
        rst();
        cmp(got, expf());
        settle(LEVEL_0DB, LEVEL_0DB);
        for (int k = 0; k < 8; k++) begin
            wr({8'h03, 5'h00, 3'(k)});
            cmp(got, expf());
        end
        wr(16'h00ff);
        cmp(got, expf());
        wr(16'h81c0);
        cmp(got, expf());
        // cut frame must be dropped and must not shift the next word
        i_dmr_host_model.send(16'h01c0, 8);
        repeat (20) @(negedge clk);
        cmp(got, expf());
        for (int k = 0; k < 16; k++) begin
            reg_index = ($urandom_range(4) == 0) ? 7'($urandom_range(127, 5))
                                                 : 7'($urandom_range(4, 1));
            w = {1'b0, reg_index, 8'($urandom) & msk[reg_index[2:0]]};
            w[15] = ($urandom_range(7) == 0);
            wr(w);
            cmp(got, expf());
        end
        wr(16'h0105);
        wr(16'h0209);
        settle(6'h05, 6'h09);
        wr(16'h0145);
        settle(6'h00, 6'h09);
        wr(16'h0185);
        settle(6'h05, 6'h00);
        wr(16'h0105);
        settle(6'h05, 6'h09);
        rst();
        cmp(got, expf());
        settle(LEVEL_0DB, LEVEL_0DB);
        results();
    end
endmodule
